// File: bench/imuspc_chain_sva.sv
`timescale 1ns/1ps
module imuspc_chain_sva #(
    parameter int PROC_CYCLES = 50,
    parameter int GYRO_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire imuspc_pkg::imuspc_raw_t raw_in,
    input wire logic sync_in,
    input wire logic gyro_sample_out,
    input wire logic data_ready_out,
    input wire logic stamp_mode_out
);
    localparam int GYRO_M1 = GYRO_CYCLES - 1;
    logic acc;
    logic wr;
    logic clean;
    logic [7:0] staged;
    logic [15:0] misc;
    int gap;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            staged <= 8'h00;
            misc <= imuspc_pkg::MISC_RESET;
        end else if (wr && paddr_in == imuspc_pkg::OFF_MISC_LO) begin
            staged <= pwdata_in[7:0];
        end else if (wr && paddr_in == imuspc_pkg::OFF_MISC_HI) begin
            misc <= {pwdata_in[7:0], staged};
        end
    end
    // gap since last update; clean while no write and no scaled sync mode (stamp_mode_out) could move the rate
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap <= 0;
            clean <= 1'b0;
        end else if (data_ready_out) begin
            gap <= 1;
            clean <= !wr && !stamp_mode_out;
        end else begin
            gap <= gap + 1;
            clean <= clean && !wr && !stamp_mode_out;
        end
    end
    property p_gyro_rate;
        gyro_sample_out |=> !gyro_sample_out ##GYRO_M1 gyro_sample_out;
    endproperty
    a_gyro_rate: assert property (p_gyro_rate) else $error("gyro sample spacing off");
    property p_rate;
        data_ready_out && clean |-> gap % PROC_CYCLES == 0;
    endproperty
    a_rate: assert property (p_rate) else $error("update spacing off");
    property p_dr_pulse;
        $rose(data_ready_out) |=> !data_ready_out [*3];
    endproperty
    a_dr_pulse: assert property (p_dr_pulse) else $error("update pulse too long");
    property p_stamp;
        $stable(misc) [*2] |-> stamp_mode_out == (misc[4:2] == imuspc_pkg::MODE_SCALED);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp mode level wrong");
    property p_ready;
        psel_in |-> pready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_unmapped;
        acc && paddr_in[1:0] == 2'h0 && (paddr_in > 8'h5C || paddr_in <= 8'h14)
            |-> pslverr_out == (paddr_in > 8'h5C);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("error response wrong");
    property p_misc_lo;
        acc && !pwrite_in && paddr_in == imuspc_pkg::OFF_MISC_LO
            |-> prdata_out == {24'h000000, misc[7:0]};
    endproperty
    a_misc_lo: assert property (p_misc_lo) else $error("misc low byte wrong");
    property p_misc_hi;
        acc && !pwrite_in && paddr_in == imuspc_pkg::OFF_MISC_HI
            |-> prdata_out == {24'h000000, misc[15:8]};
    endproperty
    a_misc_hi: assert property (p_misc_hi) else $error("misc high byte wrong");
    c_rate: cover property (data_ready_out && clean);
    c_err: cover property (acc && pslverr_out);
    c_stamp: cover property (stamp_mode_out && data_ready_out);
endmodule

// File: bench/imuspc_chain_tb.sv
`timescale 1ns/1ps
module imuspc_chain_tb;
    localparam int PC = 50;
    logic clk_in, rst_n_in, sync_in, psel, pen, pwr, prdy, perr, gs, dr, stamp;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    imuspc_pkg::imuspc_raw_t raw;
    logic [32:0] q[$];
    logic [32:0] want;
    logic [15:0] v[6];
    int mismatches, check_count, seed, cyc, t0, k;
    imuspc_host host (.clk_in(clk_in), .pready_in(prdy), .psel_out(psel), .penable_out(pen),
        .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wdata));
    imuspc_chain #(.PROC_CYCLES(PC), .GYRO_CYCLES(20)) dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(addr), .pwdata_in(wdata), .prdata_out(rdata), .pready_out(prdy),
        .pslverr_out(perr), .raw_in(raw), .sync_in(sync_in), .gyro_sample_out(gs),
        .data_ready_out(dr), .stamp_mode_out(stamp));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        q.push_back(exp);
        host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wdr;
        do @(posedge clk_in); while (dr !== 1'b1);
    endtask
    task automatic tally_and_finish;
        $display("mismatches=%0d checks=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish;
        end
        if (psel && pen && prdy === 1'b1 && pwr === 1'b0) begin
            want = q.pop_front();
            if (want[32]) chk({perr, 32'h00000000}, want);
            else chk({perr, rdata}, want);
        end
    end
    initial begin
        seed = 32'h2188;
        {cyc, mismatches, check_count} = '0;
        rst_n_in = 1'b0;
        sync_in = 1'b0;
        raw = '0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (k = 0; k < 6; k++) rd(8'(4 * k), {25'h0, (k == 0) ? 8'hC1 : 8'h00});
        rd(8'h80, {1'b1, 32'h00000000});
        host.xfer(1'b1, imuspc_pkg::OFF_MISC_LO, 8'h00);
        rd(imuspc_pkg::OFF_MISC_LO, 33'h0C1);
        host.xfer(1'b1, imuspc_pkg::OFF_MISC_HI, 8'h00);
        rd(imuspc_pkg::OFF_MISC_LO, 33'h000);
        host.cwr(imuspc_pkg::OFF_FILT_LO, 16'h0003);
        rd(imuspc_pkg::OFF_FILT_LO, 33'h003);
        host.cwr(imuspc_pkg::OFF_FILT_LO, 16'h0000);
        for (k = 0; k < 2; k++) begin
            host.cwr(imuspc_pkg::OFF_DEC_LO, 16'(3 * k));
            wdr;
            wdr;
            t0 = cyc;
            wdr;
            chk(33'(cyc - t0), 33'((3 * k + 1) * PC));
        end
        host.cwr(imuspc_pkg::OFF_DEC_LO, 16'h0000);
        for (k = 0; k < 6; k++) v[k] = 16'($random(seed));
        raw <= {v[0], v[1], v[2], v[3], v[4], v[5]};
        wdr;
        wdr;
        for (k = 0; k < 6; k++) begin
            rd(imuspc_pkg::OFF_DATA_BASE + 8'(8 * k), {25'h0, v[k][7:0]});
            rd(imuspc_pkg::OFF_DATA_BASE + 8'(8 * k + 4), {25'h0, v[k][15:8]});
        end
        host.xfer(1'b1, imuspc_pkg::OFF_DATA_BASE, ~v[0][7:0]);
        rd(imuspc_pkg::OFF_DATA_BASE, {25'h0, v[0][7:0]});
        for (k = 0; k < 8; k++) begin
            host.cwr(imuspc_pkg::OFF_MISC_LO, 16'(k << 2));
            @(posedge clk_in);
            chk({32'h0, stamp}, {32'h0, k == 2});
            if (k == 2) begin
                repeat (4) @(posedge clk_in);
                t0 = 0;
                repeat (6) begin
                    sync_in <= ~sync_in;
                    repeat (15) begin
                        @(posedge clk_in);
                        t0 += int'(dr === 1'b1);
                    end
                end
                chk(33'(t0), 33'd3);
                rd(imuspc_pkg::OFF_STAMP_LO, 33'h003);
            end
        end
        tally_and_finish;
    end
endmodule
bind imuspc_chain imuspc_chain_sva #(.PROC_CYCLES(PROC_CYCLES), .GYRO_CYCLES(GYRO_CYCLES)) u_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .raw_in(raw_in), .sync_in(sync_in), .gyro_sample_out(gyro_sample_out),
    .data_ready_out(data_ready_out), .stamp_mode_out(stamp_mode_out));

// File: bench/imuspc_host.sv
`timescale 1ns/1ps
module imuspc_host (
    input wire logic clk_in,
    input wire logic pready_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h00000000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= {24'h000000, d};
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~a;
        pwdata_out <= ~{24'h000000, d};
    endtask
    // controls only, low byte first
    task automatic cwr(input logic [7:0] a, input logic [15:0] val);
        xfer(1'b1, a, val[7:0]);
        xfer(1'b1, a + 8'h04, val[15:8]);
    endtask
endmodule

// File: src/imuspc_chain.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - default settings run continuously at 2000 SPS
// - internal clock mode is default, 2000 SPS
// - gyro sampled 4100 Hz, processed 2000 Hz
// - mode bits 4:2 select external sync modes
// - gyro: matrix, bias, linear-g term
// - accel: matrix, bias, percussion term
// - coefficients internal, never host accessible
// - bit 7 toggles gyro linear-g term
// - bit 6 toggles accel percussion term
// - two cascaded averaging stages, filter register
// - decimation averages N+1, divides update rate by N+1
// - registers 16-bit, each byte own address
// - host reads outputs, writes controls only
// - mode 010 raises stamp_mode_out; time stamp register loads the sync edge count in every mode
module imuspc_chain #(
    parameter int PROC_CYCLES = imuspc_pkg::PROC_CYC,
    parameter int GYRO_CYCLES = imuspc_pkg::GYRO_SAMPLE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire imuspc_pkg::imuspc_raw_t raw_in,
    input wire logic sync_in,
    output logic gyro_sample_out,
    output logic data_ready_out,
    output logic stamp_mode_out
);
    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CAL, ST_OUT} imuspc_state_t;

    // factory coefficients, Q2.14; not mapped on the bus
    localparam logic signed [15:0] M_DIAG = 16'sh4000;
    localparam logic signed [15:0] M_OFF = 16'sh0000;
    localparam logic signed [15:0] BIAS = 16'sh0000;
    localparam logic signed [15:0] L_COEF = 16'sh0010;
    localparam logic signed [15:0] P_COEF = 16'sh0008;

    logic [15:0] misc_control_register;
    logic [15:0] fir_filter_control;
    logic [15:0] decimation_rate_setting;
    logic [7:0] misc_lo_stage;
    logic [7:0] filt_lo_stage;
    logic [7:0] dec_lo_stage;
    imuspc_pkg::imuspc_ctrl_t ctrl;
    imuspc_state_t state;
    logic [4:0] init_cnt;
    logic [15:0] proc_cnt;
    logic [15:0] gyro_cnt;
    logic [15:0] sync_div;
    logic sync_d;
    logic sync_rise;
    logic proc_tick;
    logic dec_done;
    logic signed [15:0] gyro_held [3];
    logic signed [15:0] accel_held [3];
    logic signed [15:0] gyro_cal [3];
    logic signed [15:0] accel_cal [3];
    logic signed [23:0] stage1 [imuspc_pkg::NUM_AXES];
    logic signed [23:0] stage2 [imuspc_pkg::NUM_AXES];
    logic signed [31:0] dec_acc [imuspc_pkg::NUM_AXES];
    logic [15:0] out_reg [imuspc_pkg::NUM_AXES];
    logic [15:0] dec_cnt;
    logic [15:0] data_counter;
    logic [15:0] time_stamp;

    function automatic logic signed [15:0] sat_q14(input logic signed [35:0] v);
        logic signed [35:0] s;
        s = v >>> 14;
        if (s > 36'sd32767) begin
            return 16'sh7FFF;
        end else if (s < -36'sd32768) begin
            return 16'sh8000;
        end
        return s[15:0];
    endfunction

    function automatic logic signed [35:0] mac3(input int row, input logic signed [15:0] a,
                                                input logic signed [15:0] b,
                                                input logic signed [15:0] c);
        logic signed [15:0] k0;
        logic signed [15:0] k1;
        logic signed [15:0] k2;
        logic signed [35:0] p0;
        logic signed [35:0] p1;
        logic signed [35:0] p2;
        k0 = (row == 0) ? M_DIAG : M_OFF;
        k1 = (row == 1) ? M_DIAG : M_OFF;
        k2 = (row == 2) ? M_DIAG : M_OFF;
        // widen before multiplying so products keep their high bits
        p0 = 36'(k0) * 36'(a);
        p1 = 36'(k1) * 36'(b);
        p2 = 36'(k2) * 36'(c);
        return p0 + p1 + p2 + (36'(BIAS) <<< 14);
    endfunction

    // slot of an output data register from its byte address
    function automatic logic [2:0] data_slot(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - imuspc_pkg::OFF_DATA_BASE;
        return rel[5:3];
    endfunction

    // signed average over d+1 samples; divisor kept signed
    function automatic logic [15:0] dec_avg(input logic signed [31:0] total,
                                            input logic [15:0] d);
        logic signed [31:0] n;
        logic signed [31:0] q;
        n = $signed({16'h0000, d}) + 32'sd1;
        q = total / n;
        return q[15:0];
    endfunction

    assign ctrl.lin_g_on = misc_control_register[imuspc_pkg::MISC_LING_BIT];
    assign ctrl.pop_on = misc_control_register[imuspc_pkg::MISC_POP_BIT];
    assign ctrl.clock_mode = misc_control_register[imuspc_pkg::MISC_MODE_HI:
                                                   imuspc_pkg::MISC_MODE_LO];
    assign stamp_mode_out = (ctrl.clock_mode == imuspc_pkg::MODE_SCALED);

    // control registers: low byte staged, whole word commits on high byte
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            misc_control_register <= imuspc_pkg::MISC_RESET;
            fir_filter_control <= imuspc_pkg::FILT_RESET;
            decimation_rate_setting <= imuspc_pkg::DEC_RESET;
            misc_lo_stage <= imuspc_pkg::MISC_RESET[7:0];
            filt_lo_stage <= 8'h00;
            dec_lo_stage <= 8'h00;
        end else if (psel_in && penable_in && pwrite_in) begin
            case (paddr_in)
                imuspc_pkg::OFF_MISC_LO: misc_lo_stage <= pwdata_in[7:0];
                imuspc_pkg::OFF_FILT_LO: filt_lo_stage <= pwdata_in[7:0];
                imuspc_pkg::OFF_DEC_LO: dec_lo_stage <= pwdata_in[7:0];
                imuspc_pkg::OFF_MISC_HI: misc_control_register <= {pwdata_in[7:0], misc_lo_stage};
                imuspc_pkg::OFF_FILT_HI: fir_filter_control <= {pwdata_in[7:0], filt_lo_stage};
                imuspc_pkg::OFF_DEC_HI: decimation_rate_setting <= {pwdata_in[7:0], dec_lo_stage};
                default: ;
            endcase
        end
    end

    assign pready_out = 1'b1;
    always_comb begin
        prdata_out = 32'h0000_0000;
        pslverr_out = 1'b0;
        case (paddr_in)
            imuspc_pkg::OFF_MISC_LO: prdata_out[7:0] = misc_control_register[7:0];
            imuspc_pkg::OFF_MISC_HI: prdata_out[7:0] = misc_control_register[15:8];
            imuspc_pkg::OFF_FILT_LO: prdata_out[7:0] = fir_filter_control[7:0];
            imuspc_pkg::OFF_FILT_HI: prdata_out[7:0] = fir_filter_control[15:8];
            imuspc_pkg::OFF_DEC_LO: prdata_out[7:0] = decimation_rate_setting[7:0];
            imuspc_pkg::OFF_DEC_HI: prdata_out[7:0] = decimation_rate_setting[15:8];
            imuspc_pkg::OFF_COUNTER_LO: prdata_out[7:0] = data_counter[7:0];
            imuspc_pkg::OFF_COUNTER_HI: prdata_out[7:0] = data_counter[15:8];
            imuspc_pkg::OFF_STAMP_LO: prdata_out[7:0] = time_stamp[7:0];
            imuspc_pkg::OFF_STAMP_HI: prdata_out[7:0] = time_stamp[15:8];
            default: begin
                if (paddr_in >= imuspc_pkg::OFF_DATA_BASE && paddr_in < imuspc_pkg::OFF_COUNTER_LO) begin
                    prdata_out[7:0] = paddr_in[2] ? out_reg[data_slot(paddr_in)][15:8] :
                                                    out_reg[data_slot(paddr_in)][7:0];
                end else begin
                    pslverr_out = psel_in && penable_in;
                end
            end
        endcase
    end

    // gyro converter sample strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gyro_cnt <= 16'h0000;
            gyro_sample_out <= 1'b0;
        end else begin
            gyro_sample_out <= (gyro_cnt == 16'(GYRO_CYCLES - 1));
            gyro_cnt <= (gyro_cnt == 16'(GYRO_CYCLES - 1)) ? 16'h0000 : gyro_cnt + 16'h0001;
        end
    end

    assign sync_rise = sync_in && !sync_d;

    // processing rate: internal divider or sync pin edges
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            proc_cnt <= 16'h0000;
            sync_d <= 1'b0;
            sync_div <= 16'h0000;
            proc_tick <= 1'b0;
        end else begin
            sync_d <= sync_in;
            proc_tick <= 1'b0;
            case (ctrl.clock_mode)
                imuspc_pkg::MODE_DIRECT, imuspc_pkg::MODE_PULSE: begin
                    proc_tick <= sync_rise;
                end
                imuspc_pkg::MODE_SCALED: begin
                    if (sync_rise) begin
                        proc_tick <= 1'b1;
                    end
                end
                default: begin
                    proc_tick <= (proc_cnt == 16'(PROC_CYCLES - 1));
                    proc_cnt <= (proc_cnt == 16'(PROC_CYCLES - 1)) ? 16'h0000 : proc_cnt + 16'h0001;
                end
            endcase
            if (sync_rise) begin
                sync_div <= sync_div + 16'h0001;
            end
        end
    end

    // main sequencer: self init then free-running
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_INIT;
            init_cnt <= 5'h00;
        end else begin
            case (state)
                ST_INIT: begin
                    init_cnt <= init_cnt + 5'h01;
                    if (init_cnt == 5'(imuspc_pkg::INIT_CYC - 1)) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (proc_tick) begin
                        state <= ST_CAL;
                    end
                end
                ST_CAL: state <= ST_OUT;
                ST_OUT: state <= ST_IDLE;
                default: state <= ST_INIT;
            endcase
        end
    end

    // latch gyro and accel at the same processing tick
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 3; i++) begin
                gyro_held[i] <= 16'sh0000;
                accel_held[i] <= 16'sh0000;
            end
        end else if (state == ST_IDLE && proc_tick) begin
            gyro_held[0] <= raw_in.gyro_x;
            gyro_held[1] <= raw_in.gyro_y;
            gyro_held[2] <= raw_in.gyro_z;
            accel_held[0] <= raw_in.accel_x;
            accel_held[1] <= raw_in.accel_y;
            accel_held[2] <= raw_in.accel_z;
        end
    end

    // factory correction; accel uses pre-term gyro square, gyro uses corrected accel
    always_comb begin
        logic signed [15:0] acc_base [3];
        logic signed [15:0] gyr_base [3];
        logic signed [35:0] sq;
        logic signed [35:0] g2;
        sq = 36'sd0;
        g2 = 36'sd0;
        for (int r = 0; r < 3; r++) begin
            acc_base[r] = 16'sh0000;
            gyr_base[r] = 16'sh0000;
        end
        for (int r = 0; r < 3; r++) begin
            gyr_base[r] = sat_q14(mac3(r, gyro_held[0], gyro_held[1], gyro_held[2]));
            acc_base[r] = sat_q14(mac3(r, accel_held[0], accel_held[1], accel_held[2]));
        end
        for (int r = 0; r < 3; r++) begin
            sq = 36'sd0;
            for (int c = 0; c < 3; c++) begin
                if (c != r) begin
                    g2 = (36'(gyr_base[c]) * 36'(gyr_base[c])) >>> 15;
                    sq = sq + 36'(P_COEF) * g2;
                end
            end
            accel_cal[r] = ctrl.pop_on ? sat_q14((36'(acc_base[r]) <<< 14) + sq) :
                                         acc_base[r];
        end
        for (int r = 0; r < 3; r++) begin
            sq = 36'(gyr_base[r]) <<< 14;
            for (int c = 0; c < 3; c++) begin
                sq = sq + 36'(L_COEF) * 36'(accel_cal[c]);
            end
            gyro_cal[r] = ctrl.lin_g_on ? sat_q14(sq) : gyr_base[r];
        end
    end

    // a larger count left over from an earlier setting still ends the block
    assign dec_done = (dec_cnt >= decimation_rate_setting);

    // bartlett: two cascaded exponential averages, weight 2^-N per stage, then decimating average
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < imuspc_pkg::NUM_AXES; i++) begin
                stage1[i] <= 24'sh000000;
                stage2[i] <= 24'sh000000;
                dec_acc[i] <= 32'sh00000000;
                out_reg[i] <= 16'h0000;
            end
            dec_cnt <= 16'h0000;
            data_counter <= 16'h0000;
            time_stamp <= 16'h0000;
            data_ready_out <= 1'b0;
        end else begin
            data_ready_out <= 1'b0;
            if (state == ST_CAL) begin
                for (int i = 0; i < imuspc_pkg::NUM_AXES; i++) begin
                    logic signed [23:0] x;
                    logic [2:0] sh;
                    logic signed [23:0] s1n;
                    logic signed [23:0] s2n;
                    x = (i < 3) ? 24'(gyro_cal[i]) : 24'(accel_cal[i - 3]);
                    sh = fir_filter_control[imuspc_pkg::FILT_W-1:0];
                    s1n = stage1[i] + ((x - stage1[i]) >>> sh);
                    s2n = stage2[i] + ((s1n - stage2[i]) >>> sh);
                    stage1[i] <= s1n;
                    stage2[i] <= s2n;
                    if (dec_done) begin
                        // single commit of all axes
                        out_reg[i] <= dec_avg(dec_acc[i] + 32'(s2n), decimation_rate_setting);
                        dec_acc[i] <= 32'sh00000000;
                    end else begin
                        dec_acc[i] <= dec_acc[i] + 32'(s2n);
                    end
                end
                if (dec_done) begin
                    dec_cnt <= 16'h0000;
                    data_counter <= data_counter + 16'h0001;
                    time_stamp <= sync_div;
                    data_ready_out <= 1'b1;
                end else begin
                    dec_cnt <= dec_cnt + 16'h0001;
                end
            end
        end
    end
endmodule

// File: src/imuspc_pkg.sv
package imuspc_pkg;
    // byte addresses of the register file (each register byte one 32-bit word)
    localparam logic [7:0] OFF_MISC_LO = 8'h00;
    localparam logic [7:0] OFF_MISC_HI = 8'h04;
    localparam logic [7:0] OFF_FILT_LO = 8'h08;
    localparam logic [7:0] OFF_FILT_HI = 8'h0C;
    localparam logic [7:0] OFF_DEC_LO = 8'h10;
    localparam logic [7:0] OFF_DEC_HI = 8'h14;
    localparam logic [7:0] OFF_DATA_BASE = 8'h20;
    // six axes of two words each fill 0x20..0x4F
    localparam logic [7:0] OFF_COUNTER_LO = 8'h50;
    localparam logic [7:0] OFF_COUNTER_HI = 8'h54;
    localparam logic [7:0] OFF_STAMP_LO = 8'h58;
    localparam logic [7:0] OFF_STAMP_HI = 8'h5C;
    // misc control fields
    localparam int MISC_LING_BIT = 7;
    localparam int MISC_POP_BIT = 6;
    localparam int MISC_MODE_HI = 4;
    localparam int MISC_MODE_LO = 2;
    localparam logic [15:0] MISC_RESET = 16'h00C1;
    localparam logic [15:0] FILT_RESET = 16'h0000;
    localparam logic [15:0] DEC_RESET = 16'h0000;
    localparam int FILT_W = 3;
    // sample clock modes
    localparam logic [2:0] MODE_INTERNAL = 3'h0;
    localparam logic [2:0] MODE_DIRECT = 3'h1;
    localparam logic [2:0] MODE_SCALED = 3'h2;
    localparam logic [2:0] MODE_PULSE = 3'h5;
    // timing
    localparam int CLK_HZ = 25000000;
    localparam int GYRO_SAMPLE_HZ = 4100;
    localparam int PROC_HZ = 2000;
    localparam int GYRO_SAMPLE_CYC = CLK_HZ / GYRO_SAMPLE_HZ;
    localparam int PROC_CYC = CLK_HZ / PROC_HZ;
    localparam int INIT_CYC = 16;
    localparam int NUM_AXES = 6;
    typedef struct packed {
        logic [15:0] gyro_x;
        logic [15:0] gyro_y;
        logic [15:0] gyro_z;
        logic [15:0] accel_x;
        logic [15:0] accel_y;
        logic [15:0] accel_z;
    } imuspc_raw_t;
    typedef struct packed {
        logic lin_g_on;
        logic pop_on;
        logic [2:0] clock_mode;
    } imuspc_ctrl_t;
endpackage
